// ### shared/lrp_pkg.sv
// Constants shared by the LED driver two-wire register port.
// Assumes a 200 MHz core clock and a bus controller at or below 400 kbit/s.
package lrp_pkg;

    // Chip address pairs; the pin selects the low two address bits
    localparam logic [6:0] DEV_ADDR_BASE = 7'h48;
    localparam logic [1:0] SEL_GND       = 2'h0;
    localparam logic [1:0] SEL_SCL       = 2'h1;
    localparam logic [1:0] SEL_SDA       = 2'h2;
    localparam logic [1:0] SEL_VDD       = 2'h3;

    // Byte framing
    localparam int         PTR_W         = 6;
    localparam int         CNT_W         = 4;
    localparam logic [3:0] CNT_BYTE_DONE = 4'h8;
    localparam logic [3:0] CNT_ACK_DONE  = 4'h9;
    localparam logic       DIR_READ      = 1'h1;

    // Timing
    localparam int MAX_RATE_KBPS = 400;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int T_HD_DAT_NS   = 100;
    localparam int HOLD_CYC_INT  =
        (T_HD_DAT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLD_W        = 5;
    localparam logic [HOLD_W-1:0] HOLD_CYC = HOLD_W'(HOLD_CYC_INT);

    // Reset values
    localparam logic [PTR_W-1:0] PTR_RESET = 6'h00;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_PTR   = 3'b011,
        ST_WRITE = 3'b010,
        ST_READ  = 3'b110
    } lrp_state_e;

endpackage : lrp_pkg

// ### shared/lrp_core_if.sv
// Carrier between the port controller, link sampler and register memory.
// Assumes link_byte is written on the serial clock and read after a resync.
`timescale 1ns/10ps
interface lrp_core_if #(
    parameter int AW = 6
) ();
    logic [7:0]    link_byte;
    logic          wr_en;
    logic [AW-1:0] waddr;
    logic [AW-1:0] raddr;
    logic [7:0]    wdata;
    logic [7:0]    rdata;

    modport ctrl (input link_byte, rdata,
                  output wr_en, waddr, raddr, wdata);
    modport mem  (input wr_en, waddr, raddr, wdata,
                  output rdata);
    modport link (output link_byte);
endinterface : lrp_core_if

// ### verilog/lrp_link_shift.sv
// Serial clock domain: samples the data line on each clock rise.
// Assumes the controller holds data stable around the rising edge.
`timescale 1ns/10ps
module lrp_link_shift
    import lrp_pkg::*;
(
    // Link
    input  wire logic scl_clk_in,
    input  wire logic sda_in,
    // Core side
    lrp_core_if.link  core
);

    // Stable for a full clock period, so the core may resample it late
    always_ff @(posedge scl_clk_in) begin
        core.link_byte <= {core.link_byte[6:0], sda_in};
    end

endmodule : lrp_link_shift

// ### verilog/lrp_reg_mem.sv
// Register image written and read back by the serial port.
// Assumes one write and one registered read per core clock.
`timescale 1ns/10ps
module lrp_reg_mem
    import lrp_pkg::*;
#(
    parameter int AW = PTR_W
) (
    // Clock
    input  wire logic clock_in,
    // Access
    lrp_core_if.mem   core
);

    logic [7:0] mem_ff [2**AW];
    logic [7:0] rdata_ff;

    if (AW < 1 || AW > 8) begin : g_bad_aw
        $error("lrp_reg_mem: AW out of range");
    end

    always_ff @(posedge clock_in) begin
        if (core.wr_en) begin
            mem_ff[core.waddr] <= core.wdata;
        end
    end

    always_ff @(posedge clock_in) begin
        rdata_ff <= mem_ff[core.raddr];
    end

    assign core.rdata = rdata_ff;

endmodule : lrp_reg_mem

// ### verilog/lrp_i2c_port.sv
// Two-wire target port of the LED driver: framing, addressing, pointer,
// register writes and reads.
// Assumes open-drain pins resolved outside; bus pins are asynchronous
// to clock_in, and the serial clock also clocks the link sampler.
`timescale 1ns/10ps
module lrp_i2c_port
    import lrp_pkg::*;
#(
    parameter int MEM_AW = PTR_W
) (
    // Core clock and reset
    input  wire logic              clock_in,
    input  wire logic              rst_in,
    // Serial bus
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output wire logic              sda_out,
    output wire logic              sda_oe_out,
    // Address select strap
    input  wire logic              addr_pin_in,
    output wire logic [1:0]        addr_sel_out,
    // Register write stream to the LED engines
    output wire logic              reg_wr_out,
    output wire logic [PTR_W-1:0]  reg_addr_out,
    output wire logic [7:0]        reg_data_out
);

    if (MEM_AW != PTR_W) begin : g_bad_aw
        $error("lrp_i2c_port: MEM_AW must equal the pointer width");
    end

    lrp_core_if #(.AW(PTR_W)) core ();

    lrp_link_shift u_link (
        .scl_clk_in (scl_in),
        .sda_in     (sda_in),
        .core       (core)
    );

    lrp_reg_mem #(.AW(MEM_AW)) u_mem (
        .clock_in (clock_in),
        .core     (core)
    );

    // Pin synchronisers: bit 0 clock, bit 1 data, bit 2 address strap
    wire  [2:0] pins_raw;
    wire  [2:0] pins_s;
    assign pins_raw = {addr_pin_in, sda_in, scl_in};

    for (genvar g = 0; g < 3; g++) begin : g_sync
        logic s1_ff;
        logic s2_ff;
        always_ff @(posedge clock_in) begin
            if (rst_in) begin
                s1_ff <= 1'b1;
                s2_ff <= 1'b1;
            end else begin
                s1_ff <= pins_raw[g];
                s2_ff <= s1_ff;
            end
        end
        assign pins_s[g] = s2_ff;
    end

    wire scl_s;
    wire sda_s;
    wire addr_s;
    assign scl_s  = pins_s[0];
    assign sda_s  = pins_s[1];
    assign addr_s = pins_s[2];

    // Received byte, resampled from the link domain. It only changes on
    // a clock rise, and is read a hold time after the following fall.
    logic [7:0] byte_s1_ff;
    logic [7:0] byte_s2_ff;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            byte_s1_ff <= 8'h00;
            byte_s2_ff <= 8'h00;
        end else begin
            byte_s1_ff <= core.link_byte;
            byte_s2_ff <= byte_s1_ff;
        end
    end

    // Edge and condition detection
    logic scl_d_ff;
    logic sda_d_ff;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end

    wire scl_rise;
    wire scl_fall;
    wire start_evt;
    wire stop_evt;
    assign scl_rise  = scl_s & ~scl_d_ff;
    assign scl_fall  = ~scl_s & scl_d_ff;
    assign start_evt = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign stop_evt  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

    // Strap detection: a pin tied to a bus line never disagrees with it
    // for two cycles running; one-cycle skew between synchronisers is
    // tolerated that way.
    wire [1:0] strap_ref;
    wire [1:0] strap_seen;
    assign strap_ref = {sda_s, scl_s};

    for (genvar g = 0; g < 2; g++) begin : g_strap
        logic mis_last_ff;
        logic seen_ff;
        wire  mis_now;
        assign mis_now = addr_s ^ strap_ref[g];
        always_ff @(posedge clock_in) begin
            if (rst_in) begin
                mis_last_ff <= 1'b0;
                seen_ff     <= 1'b0;
            end else begin
                mis_last_ff <= mis_now;
                seen_ff     <= seen_ff | (mis_now & mis_last_ff);
            end
        end
        assign strap_seen[g] = seen_ff;
    end

    function automatic logic [1:0] strap_code(input logic seen_scl,
                                              input logic seen_sda,
                                              input logic level);
        logic [1:0] code;
        if (!seen_scl) begin
            code = SEL_SCL;
        end else if (!seen_sda) begin
            code = SEL_SDA;
        end else if (level) begin
            code = SEL_VDD;
        end else begin
            code = SEL_GND;
        end
        return code;
    endfunction : strap_code

    logic [1:0] sel_ff;
    wire  [1:0] nxt_sel;
    assign nxt_sel = strap_code(strap_seen[0], strap_seen[1], addr_s);

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            sel_ff <= SEL_GND;
        end else begin
            sel_ff <= nxt_sel;
        end
    end

    wire [6:0] dev_addr;
    wire       addr_hit;
    wire       dir_read;
    assign dev_addr = DEV_ADDR_BASE | {5'h00, sel_ff};
    assign addr_hit = (byte_s2_ff[7:1] == dev_addr);
    assign dir_read = (byte_s2_ff[0] == DIR_READ);

    // Output changes wait a hold time after the clock fall; the fall is
    // already three cycles late, and both stay far inside the low phase
    // that 400 kbit/s leaves.
    logic [HOLD_W-1:0] hold_ff;
    logic [HOLD_W-1:0] nxt_hold;
    wire               act_evt;
    assign act_evt = (hold_ff == HOLD_W'(1));

    always_comb begin
        nxt_hold = hold_ff;
        if (start_evt || stop_evt) begin
            nxt_hold = '0;
        end else if (scl_fall) begin
            nxt_hold = HOLD_CYC;
        end else if (hold_ff != '0) begin
            nxt_hold = hold_ff - HOLD_W'(1);
        end
    end

    // Protocol state
    lrp_state_e        state_ff;
    lrp_state_e        nxt_state;
    logic [CNT_W-1:0]  cnt_ff;
    logic [CNT_W-1:0]  nxt_cnt;
    logic [PTR_W-1:0]  ptr_ff;
    logic [PTR_W-1:0]  nxt_ptr;
    logic [7:0]        tx_ff;
    logic [7:0]        nxt_tx;
    logic              drive_ff;
    logic              nxt_drive;
    logic              wr_ff;
    logic              nxt_wr;
    logic [PTR_W-1:0]  wr_addr_ff;
    logic [PTR_W-1:0]  nxt_wr_addr;
    logic [7:0]        wr_data_ff;
    logic [7:0]        nxt_wr_data;

    wire byte_done;
    wire ack_done;
    wire host_acked;
    wire in_byte;
    assign byte_done  = (cnt_ff == CNT_BYTE_DONE);
    assign ack_done   = (cnt_ff == CNT_ACK_DONE);
    assign host_acked = ~byte_s2_ff[0];
    assign in_byte    = (cnt_ff != '0) && (cnt_ff < CNT_BYTE_DONE);

    always_comb begin
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff;
        nxt_ptr     = ptr_ff;
        nxt_tx      = tx_ff;
        nxt_drive   = drive_ff;
        nxt_wr      = 1'b0;
        nxt_wr_addr = wr_addr_ff;
        nxt_wr_data = wr_data_ff;
        if (start_evt) begin
            nxt_state = ST_ADDR;
            nxt_cnt   = '0;
            nxt_drive = 1'b0;
        end else if (stop_evt) begin
            nxt_state = ST_IDLE;
            nxt_cnt   = '0;
            nxt_drive = 1'b0;
        end else begin
            if (scl_rise && state_ff != ST_IDLE && !ack_done) begin
                nxt_cnt = cnt_ff + CNT_W'(1);
            end
            if (act_evt && byte_done) begin
                unique case (state_ff)
                    ST_ADDR: begin
                        if (addr_hit) begin
                            nxt_drive = 1'b1;
                            nxt_state = dir_read ? ST_READ : ST_PTR;
                        end else begin
                            nxt_drive = 1'b0;
                            nxt_state = ST_IDLE;
                        end
                    end
                    ST_PTR: begin
                        nxt_ptr   = byte_s2_ff[PTR_W-1:0];
                        nxt_drive = 1'b1;
                        nxt_state = ST_WRITE;
                    end
                    ST_WRITE: begin
                        nxt_wr      = 1'b1;
                        nxt_wr_addr = ptr_ff;
                        nxt_wr_data = byte_s2_ff;
                        nxt_ptr     = ptr_ff + PTR_W'(1);
                        nxt_drive   = 1'b1;
                    end
                    ST_READ: begin
                        nxt_drive = 1'b0;
                        nxt_ptr   = ptr_ff + PTR_W'(1);
                    end
                    ST_IDLE: begin
                        nxt_drive = 1'b0;
                    end
                    default: begin
                        nxt_state = ST_IDLE;
                        nxt_drive = 1'b0;
                    end
                endcase
            end else if (act_evt && ack_done) begin
                nxt_cnt   = '0;
                nxt_drive = 1'b0;
                // The sampled slot bit is our own acknowledge after the
                // read address, the host's answer after each data byte
                if (state_ff == ST_READ) begin
                    if (host_acked) begin
                        nxt_tx    = core.rdata;
                        nxt_drive = ~core.rdata[7];
                    end else begin
                        nxt_state = ST_IDLE;
                    end
                end
            end else if (act_evt && in_byte && state_ff == ST_READ) begin
                nxt_tx    = {tx_ff[6:0], 1'b0};
                nxt_drive = ~tx_ff[6];
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            hold_ff  <= '0;
            state_ff <= ST_IDLE;
            cnt_ff   <= '0;
            drive_ff <= 1'b0;
            wr_ff    <= 1'b0;
        end else begin
            hold_ff  <= nxt_hold;
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            drive_ff <= nxt_drive;
            wr_ff    <= nxt_wr;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ptr_ff     <= PTR_RESET;
            tx_ff      <= 8'h00;
            wr_addr_ff <= PTR_RESET;
            wr_data_ff <= 8'h00;
        end else begin
            ptr_ff     <= nxt_ptr;
            tx_ff      <= nxt_tx;
            wr_addr_ff <= nxt_wr_addr;
            wr_data_ff <= nxt_wr_data;
        end
    end

    // Register image access; reads follow the pointer continuously
    assign core.wr_en = wr_ff;
    assign core.waddr = wr_addr_ff;
    assign core.wdata = wr_data_ff;
    assign core.raddr = ptr_ff;

    // Open drain: only ever pulls low
    assign sda_out      = 1'b0;
    assign sda_oe_out   = drive_ff;
    assign addr_sel_out = sel_ff;
    assign reg_wr_out   = wr_ff;
    assign reg_addr_out = wr_addr_ff;
    assign reg_data_out = wr_data_ff;

endmodule : lrp_i2c_port

// ### sim/lrp_host_model.sv
// Behavioural two-wire bus controller with open-drain clock and data.
// Assumes pull-ups outside; tasks are entered on a core clock fall.
`timescale 1ns/10ps
module lrp_host_model #(
    parameter int Q_NS = 640
) (
    // Bus
    input  wire logic sda_in,
    output logic      scl_oe_out,
    output logic      sda_oe_out
);
    initial begin
        scl_oe_out = 1'b0;
        sda_oe_out = 1'b0;
    end

    // Bit of four quarters, 2.56 us, so below the rate ceiling
    task automatic put_bit(input logic b);
        #Q_NS sda_oe_out = ~b;
        #Q_NS scl_oe_out = 1'b0;
        #(2*Q_NS) scl_oe_out = 1'b1;
    endtask : put_bit

    task automatic start;
        if (scl_oe_out) begin
            #Q_NS sda_oe_out = 1'b0;
            #Q_NS scl_oe_out = 1'b0;
        end
        #Q_NS sda_oe_out = 1'b1;
        #Q_NS scl_oe_out = 1'b1;
    endtask : start

    task automatic stop;
        #Q_NS sda_oe_out = 1'b1;
        #Q_NS scl_oe_out = 1'b0;
        #Q_NS sda_oe_out = 1'b0;
        #Q_NS;
    endtask : stop

    task automatic wr_byte(input logic [7:0] d, output logic nack);
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        #Q_NS sda_oe_out = 1'b0;
        #Q_NS scl_oe_out = 1'b0;
        #Q_NS nack = sda_in;
        #Q_NS scl_oe_out = 1'b1;
    endtask : wr_byte

    task automatic rd_byte(input logic nack, output logic [7:0] d);
        // Release a quarter after the fall, so our acknowledge has hold time
        #Q_NS sda_oe_out = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #(2*Q_NS) scl_oe_out = 1'b0;
            #Q_NS d[i] = sda_in;
            #Q_NS scl_oe_out = 1'b1;
        end
        put_bit(nack);
    endtask : rd_byte
endmodule : lrp_host_model

// ### sim/lrp_i2c_port_chk.sv
// Assertions on the two-wire register port, bound to its top module.
// Assumes the bus pins are sampled raw on the core clock.
`timescale 1ns/10ps
module lrp_i2c_port_chk
    import lrp_pkg::*;
(
    // Clock and reset
    input wire logic             clock_in,
    input wire logic             rst_in,
    // Bus and write stream
    input wire logic             scl_in,
    input wire logic             sda_in,
    input wire logic             sda_oe_out,
    input wire logic             reg_wr_out,
    input wire logic [PTR_W-1:0] reg_addr_out,
    input wire logic [7:0]       reg_data_out
);
    logic             sda_d_ff;
    logic             seen_ff;
    logic [PTR_W-1:0] last_ff;
    wire              frame_w = scl_in && (sda_d_ff != sda_in);
    wire [PTR_W-1:0]  nxt_addr = last_ff + 6'h01;

    always_ff @(posedge clock_in) begin
        sda_d_ff <= sda_in;
        seen_ff  <= !rst_in && !frame_w && (seen_ff || reg_wr_out);
        if (reg_wr_out) begin
            last_ff <= reg_addr_out;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    sequence s_start; scl_in && $fell(sda_in); endsequence
    sequence s_stop; scl_in && $rose(sda_in); endsequence
    sequence s_high; $stable(sda_oe_out) [*8]; endsequence

    property p_rst_clear;
        $fell(rst_in) |-> !sda_oe_out && !reg_wr_out
            && reg_addr_out == 6'h00 && reg_data_out == 8'h00;
    endproperty
    property p_wr_pulse; reg_wr_out |=> !reg_wr_out; endproperty
    // Strobe and acknowledge pull are launched by the same edge
    property p_wr_ack;
        reg_wr_out |-> sda_oe_out && !$past(sda_oe_out);
    endproperty
    property p_oe_low;
        $rose(sda_oe_out) |-> !scl_in && !$past(scl_in, 20);
    endproperty
    property p_oe_high; $rose(scl_in) |-> s_high; endproperty
    property p_wr_hold;
        !reg_wr_out |-> $stable(reg_addr_out) && $stable(reg_data_out);
    endproperty
    property p_succ; reg_wr_out && seen_ff |-> reg_addr_out == nxt_addr;
    endproperty
    property p_start_rel; s_start |-> ##[1:6] !sda_oe_out; endproperty
    property p_stop_rel; s_stop |-> ##[1:6] !sda_oe_out; endproperty

    a_rst_clear: assert property (p_rst_clear)
        else $error("outputs not cleared by reset");
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("write strobe longer than one cycle");
    a_wr_ack: assert property (p_wr_ack)
        else $error("write strobe not aligned with acknowledge start");
    a_oe_low: assert property (p_oe_low)
        else $error("data pulled while clock high");
    a_oe_high: assert property (p_oe_high)
        else $error("data drive changed in clock high phase");
    a_wr_hold: assert property (p_wr_hold)
        else $error("write stream changed without strobe");
    a_succ: assert property (p_succ)
        else $error("continuous write address not successive");
    a_start_rel: assert property (p_start_rel)
        else $error("data not released after start");
    a_stop_rel: assert property (p_stop_rel)
        else $error("data not released after stop");
endmodule : lrp_i2c_port_chk

bind lrp_i2c_port lrp_i2c_port_chk i_chk (
    .clock_in     (clock_in),
    .rst_in       (rst_in),
    .scl_in       (scl_in),
    .sda_in       (sda_in),
    .sda_oe_out   (sda_oe_out),
    .reg_wr_out   (reg_wr_out),
    .reg_addr_out (reg_addr_out),
    .reg_data_out (reg_data_out)
);

// ### sim/tb_led_driver_i2c_register_port.sv
// Self-checking bench for the two-wire register port of the LED driver.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module tb_led_driver_i2c_register_port;
    logic       clock_in = 1'b0;
    logic       rst_in   = 1'b1;
    logic [1:0] strap    = 2'h0;
    logic       scl_oe;
    logic       h_oe;
    logic       d_oe;
    logic       d_lvl;
    logic       wr;
    logic       nack;
    logic [1:0] sel_w;
    logic [5:0] waddr;
    logic [7:0] wdata;
    logic [7:0] rd;
    logic [13:0] wq[$];
    int         mismatches = 0;
    int         checks = 0;
    int         cycles = 0;
    wire        scl_w = ~scl_oe;
    wire        sda_w = d_oe ? d_lvl & ~h_oe : ~h_oe;
    wire        pin_w = strap == 2'h0 ? 1'b0 : strap == 2'h1 ? scl_w
                      : strap == 2'h2 ? sda_w : 1'b1;

    always #2.5 clock_in = ~clock_in;

    lrp_i2c_port i_dut (
        .clock_in     (clock_in),
        .rst_in       (rst_in),
        .scl_in       (scl_w),
        .sda_in       (sda_w),
        .sda_out      (d_lvl),
        .sda_oe_out   (d_oe),
        .addr_pin_in  (pin_w),
        .addr_sel_out (sel_w),
        .reg_wr_out   (wr),
        .reg_addr_out (waddr),
        .reg_data_out (wdata)
    );
    lrp_host_model i_host (
        .sda_in     (sda_w),
        .scl_oe_out (scl_oe),
        .sda_oe_out (h_oe)
    );

    // Mid-cycle sampling sees the write stream settled
    always @(negedge clock_in) begin
        cycles++;
        if (wr === 1'b1) begin
            wq.push_back({waddr, wdata});
        end
        // About 90k cycles of traffic; ceiling keeps a small margin
        if (cycles == 32'h0001_7ED0) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic chk(input string what, input logic [13:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    task automatic do_reset(input logic [1:0] s);
        @(negedge clock_in);
        rst_in = 1'b1;
        strap  = s;
        repeat (4) @(negedge clock_in);
        rst_in = 1'b0;
        repeat (12) @(negedge clock_in);
    endtask : do_reset

    task automatic wb(input logic [7:0] d, input logic exp);
        i_host.wr_byte(d, nack);
        chk("ack", 14'(nack), 14'(exp));
    endtask : wb

    task automatic t_strap;
        for (int s = 0; s < 4; s++) begin
            do_reset(2'(s));
            i_host.start();
            wb(8'h90 + 8'(2 * s), 1'b0);
            i_host.stop();
            chk("addr_sel", 14'(sel_w), 14'(s));
        end
        $display("strap test done");
    endtask : t_strap

    task automatic t_write;
        i_host.start();
        wb(8'h96, 1'b0);
        wb(8'hFF, 1'b0);
        wb(8'hC3, 1'b0);
        wb(8'h3C, 1'b0);
        i_host.stop();
        chk("writes", 14'(wq.size()), 14'h0002);
        chk("write0", wq[0], {6'h3F, 8'hC3});
        chk("write1", wq[1], {6'h00, 8'h3C});
        chk("hold", {waddr, wdata}, {6'h00, 8'h3C});
        $display("write test done");
    endtask : t_write

    task automatic t_read;
        i_host.start();
        wb(8'h96, 1'b0);
        wb(8'h7F, 1'b0);
        i_host.start();
        wb(8'h97, 1'b0);
        i_host.rd_byte(1'b0, rd);
        chk("read0", 14'(rd), 14'h00C3);
        i_host.rd_byte(1'b1, rd);
        chk("read1", 14'(rd), 14'h003C);
        i_host.stop();
        chk("no write", 14'(wq.size()), 14'h0002);
        $display("read test done");
    endtask : t_read

    task automatic t_wrong;
        i_host.start();
        wb(8'h90, 1'b1);
        wb(8'h05, 1'b1);
        i_host.start();
        wb(8'h96, 1'b0);
        wb(8'h05, 1'b0);
        wb(8'h5A, 1'b0);
        i_host.stop();
        chk("writes", 14'(wq.size()), 14'h0003);
        chk("write2", wq[2], {6'h05, 8'h5A});
        $display("address mismatch test done");
    endtask : t_wrong

    initial begin
        t_strap();
        t_write();
        t_read();
        t_wrong();
        stop_test();
    end
endmodule : tb_led_driver_i2c_register_port
